// ---- common/mics_pkg.sv ----
// mics_pkg: constants for the modem initialisation command sender
// assumes a single 20 MHz system clock and no software-visible bus
// ****************************************************************
// ****************************************************************
package mics_pkg;
  typedef enum logic [1:0] {
    MICS_MODE_NONE = 2'h0,
    MICS_MODE_USER = 2'h1,
    MICS_MODE_PP_CH1 = 2'h2,
    MICS_MODE_PP_CH2 = 2'h3
  } mics_mode_t;
  localparam int MICS_HEAD_STD = 1000;
  localparam int MICS_LAST_STD = 1059;
  localparam int MICS_HEAD_SMALL = 200;
  localparam int MICS_LAST_SMALL = 255;
  localparam logic [7:0] MICS_CR = 8'h0D;
  localparam logic [7:0] MICS_LF = 8'h0A;
  localparam int MICS_CLK_HZ = 20000000;
  localparam int MICS_BAUD = 9600;
  localparam int MICS_BIT_CYC = MICS_CLK_HZ / MICS_BAUD;
  // error codes, held as binary numbers
  localparam logic [15:0] MICS_ERR_NONE = 16'h0000;
  localparam logic [15:0] MICS_ERR_LINE = 16'd6301;
  localparam logic [15:0] MICS_ERR_CHAR = 16'd6302;
  localparam logic [15:0] MICS_ERR_SUM = 16'd6303;
  localparam logic [15:0] MICS_ERR_FMT = 16'd6304;
  localparam logic [15:0] MICS_ERR_CMD = 16'd6305;
  localparam logic [15:0] MICS_ERR_TMO = 16'd6306;
  localparam logic [15:0] MICS_ERR_INIT = 16'd6307;
  localparam logic [15:0] MICS_ERR_NET = 16'd6308;
  localparam logic [15:0] MICS_ERR_PL_CHAR = 16'd6312;
  localparam logic [15:0] MICS_ERR_PL_SUM = 16'd6313;
  localparam logic [15:0] MICS_ERR_PL_FMT = 16'd6314;
  localparam logic [15:0] MICS_ERR_DRIVE = 16'd6320;
  localparam int MICS_NUM_EV = 12;
  typedef enum logic [4:0] {
    MICS_ST_IDLE = 5'h01,
    MICS_ST_SCAN = 5'h02,
    MICS_ST_FETCH = 5'h04,
    MICS_ST_SEND = 5'h08,
    MICS_ST_DONE = 5'h10
  } mics_state_t;
endpackage : mics_pkg

// ---- src/mics_sender.sv ----
// mics_sender: sends the modem init string once after reset and keeps the error flag and code
// assumes the word store answers a read in the cycle after word_rd, and error events are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module mics_sender #(
  parameter bit SMALL_VARIANT = 1'b0,
  parameter int BIT_CYC = mics_pkg::MICS_BIT_CYC
) (
  input wire logic clk_sys, // system clock 20 MHz
  input wire logic nrst, // async active-low reset
  input wire logic [1:0] init_mode, // modem initialisation setting
  output logic word_rd, // read strobe to word store
  output logic [15:0] word_idx_q, // word index being read
  input wire logic [15:0] word_data, // word value, valid cycle after word_rd
  input wire logic word_set, // word holds a value
  output logic txd_q, // serial data out, idle high
  output logic busy, // string scan or send in progress
  output logic sent_q, // string sent completely
  input wire logic [11:0] err_ev, // error event pulses, one per code
  input wire logic err_clr, // software clear of flag and code
  output logic serial_error_flag, // communication error flag
  output logic [15:0] serial_error_code // last error code
);
  localparam int HEAD = SMALL_VARIANT ? mics_pkg::MICS_HEAD_SMALL : mics_pkg::MICS_HEAD_STD;
  localparam int LAST = SMALL_VARIANT ? mics_pkg::MICS_LAST_SMALL : mics_pkg::MICS_LAST_STD;
  localparam logic [15:0] HEAD16 = 16'(HEAD);
  localparam logic [15:0] LAST16 = 16'(LAST);
  localparam logic [15:0] BITC16 = 16'(BIT_CYC - 1);

  // refuse bit times that the 16-bit baud counter cannot hold
  if (BIT_CYC < 2 || BIT_CYC > 65535)
  begin : g_bad_bit_cyc
    $error("mics_sender: BIT_CYC out of range");
  end

  // ****************************************************************
  // reset synchroniser
  // ****************************************************************
  logic rst_s1_q;
  logic rst_n_q;
  // two flops release reset synchronously
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // ****************************************************************
  // mode decode and character framing
  // ****************************************************************
  mics_pkg::mics_state_t state_q;
  mics_pkg::mics_state_t state_d;
  logic mode_on;
  logic seven_bit;
  logic [15:0] scan_idx_q;
  logic term_ok_q;
  logic prev_cr_q;
  logic [15:0] last_idx_q;
  logic [7:0] ch;
  logic [10:0] frame;
  logic [10:0] shift_q;
  logic [3:0] nbits;
  logic [3:0] bit_left_q;
  logic [15:0] baud_q;
  logic baud_end;
  logic is_init_err;
  logic start_go;
  logic rd_fire;
  logic pend_q;
  logic started_q;

  // send only in the three initialisation modes
  assign mode_on = (init_mode != mics_pkg::MICS_MODE_NONE);
  // user mode is 7 data bits even parity, preset modes 8 data bits none
  assign seven_bit = (init_mode == mics_pkg::MICS_MODE_USER);
  // 7-bit characters keep only the low seven bits
  assign ch = seven_bit ? {1'b0, word_data[6:0]} : word_data[7:0];
  // lsb first: start, data, parity (user mode), stop, idle pad
  assign frame = seven_bit ? {2'b11, ^ch[6:0], ch[6:0], 1'b0} : {2'b11, ch, 1'b0};
  assign nbits = 4'hA;
  assign baud_end = (baud_q == BITC16);
  assign start_go = (state_q == mics_pkg::MICS_ST_IDLE) && !started_q && mode_on;
  assign rd_fire = (state_q == mics_pkg::MICS_ST_SCAN || state_q == mics_pkg::MICS_ST_FETCH) && !pend_q;
  assign word_rd = rd_fire;
  assign busy = (state_q == mics_pkg::MICS_ST_SCAN) || (state_q == mics_pkg::MICS_ST_FETCH)
             || (state_q == mics_pkg::MICS_ST_SEND);
  assign is_init_err = (state_q == mics_pkg::MICS_ST_SCAN) && pend_q
                    && ((!word_set && !term_ok_q) || (word_set && scan_idx_q == LAST16
                    && !(prev_cr_q && word_data[7:0] == mics_pkg::MICS_LF)));

  // ****************************************************************
  // sequencer: scan checks terminator, fetch/send transmits words
  // ****************************************************************
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      mics_pkg::MICS_ST_IDLE:
      begin
        if (start_go)
        begin
          state_d = mics_pkg::MICS_ST_SCAN;
        end
      end
      mics_pkg::MICS_ST_SCAN:
      begin
        if (pend_q)
        begin
          if (is_init_err)
          begin
            state_d = mics_pkg::MICS_ST_DONE;
          end
          else if (!word_set || scan_idx_q == LAST16)
          begin
            state_d = mics_pkg::MICS_ST_FETCH;
          end
        end
      end
      mics_pkg::MICS_ST_FETCH:
      begin
        if (pend_q)
        begin
          state_d = mics_pkg::MICS_ST_SEND;
        end
      end
      mics_pkg::MICS_ST_SEND:
      begin
        if (bit_left_q == 4'h0 && baud_end)
        begin
          state_d = (scan_idx_q == last_idx_q) ? mics_pkg::MICS_ST_DONE : mics_pkg::MICS_ST_FETCH;
        end
      end
      mics_pkg::MICS_ST_DONE:
      begin
        state_d = mics_pkg::MICS_ST_DONE;
      end
      default:
      begin
        state_d = mics_pkg::MICS_ST_IDLE;
      end
    endcase
  end

  // state and read pipeline
  always_ff @(posedge clk_sys or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q <= mics_pkg::MICS_ST_IDLE;
      pend_q <= 1'b0;
      started_q <= 1'b0;
      sent_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      pend_q <= rd_fire;
      started_q <= started_q | start_go;
      sent_q <= sent_q | ((state_q == mics_pkg::MICS_ST_SEND) && (state_d == mics_pkg::MICS_ST_DONE));
    end
  end

  // word index walks upward from the head index
  always_ff @(posedge clk_sys or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      scan_idx_q <= 16'h0000;
      word_idx_q <= 16'h0000;
      last_idx_q <= 16'h0000;
      term_ok_q <= 1'b0;
      prev_cr_q <= 1'b0;
    end
    else
    begin
      if (start_go)
      begin
        scan_idx_q <= HEAD16;
        word_idx_q <= HEAD16;
        term_ok_q <= 1'b0;
        prev_cr_q <= 1'b0;
      end
      else if (state_q == mics_pkg::MICS_ST_SCAN && pend_q)
      begin
        // last two stored characters must be CR then LF
        if (word_set)
        begin
          term_ok_q <= prev_cr_q && (word_data[7:0] == mics_pkg::MICS_LF);
          prev_cr_q <= (word_data[7:0] == mics_pkg::MICS_CR);
          last_idx_q <= scan_idx_q;
        end
        if (word_set && scan_idx_q != LAST16)
        begin
          scan_idx_q <= scan_idx_q + 16'h0001;
          word_idx_q <= scan_idx_q + 16'h0001;
        end
        else
        begin
          scan_idx_q <= HEAD16; // first empty word ends the string
          word_idx_q <= HEAD16;
        end
      end
      else if (state_q == mics_pkg::MICS_ST_SEND && bit_left_q == 4'h0 && baud_end)
      begin
        scan_idx_q <= scan_idx_q + 16'h0001;
        word_idx_q <= scan_idx_q + 16'h0001;
      end
    end
  end

  // ****************************************************************
  // serial transmitter
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      shift_q <= 11'h7FF;
      bit_left_q <= 4'h0;
      baud_q <= 16'h0000;
      txd_q <= 1'b1;
    end
    else if (state_q == mics_pkg::MICS_ST_FETCH && pend_q)
    begin
      shift_q <= {1'b1, frame[10:1]};
      txd_q <= frame[0];
      bit_left_q <= nbits - (seven_bit ? 4'h0 : 4'h1);
      baud_q <= 16'h0000;
    end
    else if (state_q == mics_pkg::MICS_ST_SEND)
    begin
      baud_q <= baud_end ? 16'h0000 : baud_q + 16'h0001;
      if (baud_end && bit_left_q != 4'h0)
      begin
        txd_q <= shift_q[0];
        shift_q <= {1'b1, shift_q[10:1]};
        bit_left_q <= bit_left_q - 4'h1;
      end
    end
    else
    begin
      txd_q <= 1'b1;
    end
  end

  // ****************************************************************
  // error flag and code
  // ****************************************************************
  logic [15:0] ev_code [mics_pkg::MICS_NUM_EV];
  logic [15:0] ev_pick [mics_pkg::MICS_NUM_EV + 1];
  logic [mics_pkg::MICS_NUM_EV-1:0] ev_all;
  logic err_q;
  logic [15:0] code_q;

  assign ev_code[0] = mics_pkg::MICS_ERR_LINE;
  assign ev_code[1] = mics_pkg::MICS_ERR_CHAR;
  assign ev_code[2] = mics_pkg::MICS_ERR_SUM;
  assign ev_code[3] = mics_pkg::MICS_ERR_FMT;
  assign ev_code[4] = mics_pkg::MICS_ERR_CMD;
  assign ev_code[5] = mics_pkg::MICS_ERR_TMO;
  assign ev_code[6] = mics_pkg::MICS_ERR_INIT;
  assign ev_code[7] = mics_pkg::MICS_ERR_NET;
  assign ev_code[8] = mics_pkg::MICS_ERR_PL_CHAR;
  assign ev_code[9] = mics_pkg::MICS_ERR_PL_SUM;
  assign ev_code[10] = mics_pkg::MICS_ERR_PL_FMT;
  assign ev_code[11] = mics_pkg::MICS_ERR_DRIVE;
  // own init failure merges with event 6
  assign ev_all = err_ev | {5'h00, is_init_err, 6'h00};
  assign ev_pick[mics_pkg::MICS_NUM_EV] = mics_pkg::MICS_ERR_NONE;

  // lowest set event wins the code
  genvar gi;
  generate
    for (gi = 0; gi < mics_pkg::MICS_NUM_EV; gi++)
    begin : g_pick
      assign ev_pick[gi] = ev_all[gi] ? ev_code[gi] : ev_pick[gi+1];
    end
  endgenerate

  // events set over a same-cycle clear; values hold otherwise
  always_ff @(posedge clk_sys or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      err_q <= 1'b0;
      code_q <= mics_pkg::MICS_ERR_NONE;
    end
    else if (|ev_all)
    begin
      err_q <= 1'b1;
      code_q <= ev_pick[0];
    end
    else if (err_clr)
    begin
      err_q <= 1'b0;
      code_q <= mics_pkg::MICS_ERR_NONE;
    end
  end

  assign serial_error_flag = err_q;
  assign serial_error_code = code_q;
endmodule : mics_sender
`default_nettype wire

// ---- test/mics_chk.sv ----
// mics_chk: port assertions for the modem init sender
// assumes it is bound onto mics_sender and sees one clock domain
`timescale 1ns/1ps
`default_nettype none
module mics_chk #(
  parameter bit SMALL_VARIANT = 1'b0,
  parameter int BIT_CYC = mics_pkg::MICS_BIT_CYC
) (
  input wire logic clk_sys, // clock
  input wire logic nrst, // reset
  input wire logic [1:0] init_mode, // mode
  input wire logic word_rd, // read
  input wire logic [15:0] word_idx_q, // index
  input wire logic txd_q, // line
  input wire logic busy, // active
  input wire logic sent_q, // done
  input wire logic [11:0] err_ev, // events
  input wire logic err_clr, // clear
  input wire logic serial_error_flag, // flag
  input wire logic [15:0] serial_error_code // code
);
  // ****
  // checks
  // ****
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  localparam int HEAD = SMALL_VARIANT ? mics_pkg::MICS_HEAD_SMALL : mics_pkg::MICS_HEAD_STD;
  localparam int LAST = SMALL_VARIANT ? mics_pkg::MICS_LAST_SMALL : mics_pkg::MICS_LAST_STD;
  logic [15:0] run_q; // cycles since the line last moved
  logic [15:0] code_d; // code due for the lowest event
  // lowest event index wins
  always_comb
  begin
    code_d = 16'h0000;
    for (int i = 11; i >= 0; i--)
      if (err_ev[i])
        code_d = i < 8 ? 16'h189D + 16'(i) : (i < 11 ? 16'h18A0 + 16'(i) : 16'h18B0);
  end
  // bit length counter, saturating
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      run_q <= 16'hFFFF;
    else if (txd_q != $past(txd_q))
      run_q <= 16'h0001;
    else if (run_q != 16'hFFFF)
      run_q <= run_q + 16'h0001;
  sequence s_ev;
    |err_ev;
  endsequence
  a_bit_width: assert property (txd_q != $past(txd_q) |-> run_q >= BIT_CYC) else $error("bit too short");
  a_start_busy: assert property ($fell(txd_q) |-> busy) else $error("start bit while idle");
  a_none_quiet: assert property (init_mode == 2'h0 |-> !busy && !word_rd && txd_q) else $error("active, no mode");
  a_idx_range: assert property (word_rd |-> word_idx_q >= HEAD && word_idx_q <= LAST) else $error("bad index");
  a_rd_pulse: assert property (word_rd |=> !word_rd) else $error("read held");
  a_sent_final: assert property (sent_q |-> !busy && txd_q ##1 sent_q) else $error("active after send");
  a_err_flag: assert property (s_ev |=> serial_error_flag) else $error("flag not set");
  a_err_code: assert property (s_ev |=> serial_error_code == $past(code_d)) else $error("wrong code");
  a_flag_code: assert property (serial_error_flag |-> serial_error_code != 16'h0000) else $error("no code");
  a_err_clear: assert property (err_clr && err_ev == 12'h000
    |=> !serial_error_flag && serial_error_code == 16'h0000) else $error("clear failed");
  // only the sender's own init failure may move the error state without an event
  a_err_hold: assert property (!err_clr && err_ev == 12'h000
    |=> ($stable(serial_error_code) && $stable(serial_error_flag))
    || ($past(busy) && serial_error_flag && serial_error_code == mics_pkg::MICS_ERR_INIT))
    else $error("error state moved");
endmodule : mics_chk
bind mics_sender mics_chk #(.SMALL_VARIANT(SMALL_VARIANT), .BIT_CYC(BIT_CYC)) mics_chk_inst (
  .clk_sys(clk_sys), .nrst(nrst), .init_mode(init_mode), .word_rd(word_rd), .word_idx_q(word_idx_q),
  .txd_q(txd_q), .busy(busy), .sent_q(sent_q), .err_ev(err_ev), .err_clr(err_clr),
  .serial_error_flag(serial_error_flag), .serial_error_code(serial_error_code));
`default_nettype wire

// ---- test/mics_store.sv ----
// mics_store: word store model holding the command string
// assumes reads of indices 1000 upward, answered one cycle later
`timescale 1ns/1ps
`default_nettype none
module mics_store (
  input wire logic clk_sys, // clock
  input wire logic word_rd, // read strobe
  input wire logic [15:0] word_idx_q, // index
  output logic [15:0] word_data, // word value
  output logic word_set // word has value
);
  // ****
  // store
  // ****
  logic [16:0] mem [0:63]; // bit 16 marks a set word, low byte one 7-bit char
  logic [16:0] q = 17'h00000;
  logic live = 1'b0;
  // answer the cycle after the strobe
  always @(posedge clk_sys)
  begin
    live <= word_rd;
    if (word_rd)
      q <= mem[word_idx_q - 16'h03E8];
  end
  // outside an answer the lines show the inverse of the last value
  assign word_data = live ? q[15:0] : ~q[15:0];
  assign word_set = live ? q[16] : ~q[16];
endmodule : mics_store
`default_nettype wire

// ---- test/mics_sender_tb.sv ----
// mics_sender_tb: scenario bench for the modem init sender
// assumes the store model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module mics_sender_tb;
  // ****
  // bench
  // ****
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] init_mode = 2'h0;
  logic [11:0] err_ev = 12'h000;
  logic err_clr = 1'b0;
  wire word_rd, word_set, txd_q, busy, sent_q, serial_error_flag;
  wire [15:0] word_idx_q, word_data, serial_error_code;
  int n_fail = 0;
  int n_tests = 0;
  // 20 MHz clock
  always #25 clk_sys = ~clk_sys;
  mics_sender #(.BIT_CYC(4)) mics_sender_inst (
    .clk_sys(clk_sys), .nrst(nrst), .init_mode(init_mode), .word_rd(word_rd), .word_idx_q(word_idx_q),
    .word_data(word_data), .word_set(word_set), .txd_q(txd_q), .busy(busy), .sent_q(sent_q), .err_ev(err_ev),
    .err_clr(err_clr), .serial_error_flag(serial_error_flag), .serial_error_code(serial_error_code));
  mics_store mics_store_inst (.clk_sys(clk_sys), .word_rd(word_rd), .word_idx_q(word_idx_q),
    .word_data(word_data), .word_set(word_set));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic results();
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  task automatic expire(input string what);
    check(what, 16'h0000, 16'h0001);
    results();
  endtask : expire
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #5;
  endtask : step
  task automatic boot(input logic [1:0] mode);
    nrst = 1'b0;
    init_mode = mode;
    step(4);
    nrst = 1'b1;
    step(2); // internal reset copy releases two edges later
  endtask : boot
  task automatic load(input string s);
    for (int i = 0; i < 64; i++)
      mics_store_inst.mem[i] = 17'h00000;
    for (int i = 0; i < s.len(); i++)
      mics_store_inst.mem[i] = {9'h100, s[i]};
  endtask : load
  // receive one frame at mid-bit points
  task automatic rx(input int nd, input logic par, input logic [7:0] exp);
    int t;
    logic [7:0] v;
    v = 8'h00;
    for (t = 0; t < 500 && txd_q === 1'b1; t++)
      step(1);
    if (t == 500)
      expire("frame start");
    step(2);
    check("start bit", txd_q, 1'b0);
    check("busy", busy, 1'b1);
    for (int i = 0; i < nd; i++)
    begin
      step(4);
      v[i] = txd_q;
    end
    check("char", v, exp);
    if (par)
    begin
      step(4);
      check("parity", txd_q, ^v);
    end
    step(4);
    check("stop bit", txd_q, 1'b1);
  endtask : rx
  task automatic t_none();
    logic acc;
    load("AT\015\012");
    boot(2'h0);
    acc = 1'b0;
    repeat (300)
    begin
      step(1);
      acc = acc | word_rd | ~txd_q | busy;
    end
    check("quiet line", acc, 1'b0);
    check("sent", sent_q, 1'b0);
    $display("test none done");
  endtask : t_none
  task automatic t_send(input logic [1:0] mode);
    string s;
    logic acc;
    s = "AT09\015\012";
    load(s);
    mics_store_inst.mem[7] = 17'h1005A;
    boot(mode);
    for (int i = 0; i < s.len(); i++)
      rx(mode == 2'h1 ? 7 : 8, mode == 2'h1, s[i]);
    acc = 1'b0;
    repeat (200)
    begin
      step(1);
      acc = acc | ~txd_q;
    end
    check("no char past hole", acc, 1'b0);
    check("sent", sent_q, 1'b1);
    $display("test send mode %0d done", mode);
  endtask : t_send
  task automatic t_noterm();
    int t;
    logic acc;
    load("AT\015");
    boot(2'h1);
    acc = 1'b0;
    for (t = 0; t < 500 && serial_error_flag !== 1'b1; t++)
    begin
      step(1);
      acc = acc | ~txd_q;
    end
    if (t == 500)
      expire("init error");
    check("code", serial_error_code, 16'h18A3);
    check("no send", acc, 1'b0);
    $display("test no terminator done");
  endtask : t_noterm
  task automatic t_err();
    logic [15:0] codes [12] = '{16'h189D, 16'h189E, 16'h189F, 16'h18A0, 16'h18A1, 16'h18A2, 16'h18A3,
      16'h18A4, 16'h18A8, 16'h18A9, 16'h18AA, 16'h18B0};
    boot(2'h0);
    for (int i = 0; i < 12; i++)
    begin
      err_ev = 12'h001 << i;
      step(1);
      err_ev = 12'h000;
      step(3);
      check("flag", serial_error_flag, 1'b1);
      check("code", serial_error_code, codes[i]);
      err_clr = 1'b1;
      step(1);
      err_clr = 1'b0;
      step(1);
      check("cleared flag", serial_error_flag, 1'b0);
      check("cleared code", serial_error_code, 16'h0000);
    end
    err_ev = 12'h0C0;
    err_clr = 1'b1;
    step(1);
    err_ev = 12'h000;
    err_clr = 1'b0;
    step(1);
    check("coincident flag", serial_error_flag, 1'b1);
    check("coincident code", serial_error_code, 16'h18A3);
    boot(2'h0);
    check("reset code", serial_error_code, 16'h0000);
    $display("test errors done");
  endtask : t_err
  initial
  begin
    t_none();
    for (int m = 1; m < 4; m++)
      t_send(2'(m));
    t_noterm();
    t_err();
    results();
  end
endmodule : mics_sender_tb
`default_nettype wire
